/* rtl/conv_ctrl_pkg.sv */
package conv_ctrl_pkg;

    // Register offsets on the plain register port
    localparam logic [3:0] CTRL_STATUS_OFS = 4'h0; // converter_control_status
    localparam logic [3:0] TRIG_CTRL_OFS = 4'h1;   // ext_trigger_enable
    localparam logic [3:0] RESULT_OFS = 4'h2;      // Base of four result words

    // Control/status field positions
    localparam int CH_LSB = 0;      // Three channel select bits
    localparam int CKS_BIT = 3;
    localparam int SCAN_BIT = 4;
    localparam int START_BIT = 5;   // conv_start_bit
    localparam int IE_BIT = 6;      // conv_end_request_enable
    localparam int DONE_BIT = 7;    // conv_done_flag
    localparam int TRIG_EN_BIT = 7; // In the trigger control register

    // Reset values
    localparam logic [7:0] CTRL_STATUS_RST = 8'h00;
    localparam logic [7:0] TRIG_CTRL_RD_ONES = 8'h7F; // Reserved bits read 1

    // Widths
    localparam int RES_W = 10;      // Result word width
    localparam logic [RES_W-1:0] RES_MIN = 10'h000;
    localparam logic [RES_W-1:0] RES_MAX = 10'h3FF;

    // Conversion length in states
    localparam logic [8:0] CONV_STATES_SLOW = 9'h100; // 256 states
    localparam logic [8:0] CONV_STATES_FAST = 9'h080; // 128 states

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01,
        ST_NEXT = 2'b10
    } conv_state_t;

endpackage

/* rtl/conv_ctrl.sv */
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module conv_ctrl
    import conv_ctrl_pkg::*;
(
    input wire logic mclk,                 // System clock
    input wire logic sys_rst,              // Synchronous reset
    input wire logic [3:0] regAddr,        // Register address
    input wire logic [7:0] regWdata,       // Write data
    input wire logic regWr,                // Write strobe
    input wire logic regRd,                // Read strobe
    input wire logic regDma,               // Access made by dma_controller
    output logic [7:0] regRdata,           // Read data, one cycle later
    input wire logic extConvTriggerPin_n,  // ext_conv_trigger_pin, low active
    input wire logic [RES_W-1:0] sarCode,  // Comparator code at sample end
    output logic convEndRequest,           // conv_end_request to INTC/DMA
    output logic [7:0] analogInputPin,     // Port C pin in analog role
    output logic [2:0] sarChannel          // Channel under conversion
);

    // Sequencer state; every output below comes straight from a flop
    // so the DMA side and the port pins never see decode glitches
    conv_state_t state_r, state_nxt;
    logic [7:0] csr_r, csr_nxt;
    logic trigEn_r, trigEn_nxt;
    logic trigPrev_r, trigPrev_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic [2:0] chan_r, chan_nxt;
    logic [RES_W-1:0] result_r [0:3];
    logic [RES_W-1:0] result_nxt [0:3];
    logic [7:0] rdata_r, rdata_nxt;
    logic req_r, req_nxt;
    logic [7:0] pins_r, pins_nxt;
    logic [2:0] firstCh, lastCh;
    logic trigFall, convDone, csrWr;
    logic [3:0] rIdx;

    // Pin role helpers, taken from the values after this edge
    logic [7:0] pinClaim;
    logic grpSel, scanNxt;
    logic [1:0] grpLast;

    // Group bounds below drive the sequencer only; the pin role uses
    // the next-state values so a starting write is seen at once

    // Group bounds from channel select; bit 2 chooses the group
    always_comb begin
        firstCh = {csr_r[CH_LSB+2], 2'b00};
        lastCh = csr_r[SCAN_BIT] ? csr_r[CH_LSB+2:CH_LSB]
                                 : csr_r[CH_LSB+2:CH_LSB];
        if (!csr_r[SCAN_BIT]) begin
            firstCh = csr_r[CH_LSB+2:CH_LSB];
        end
    end

    // Trigger edge: the previous pin level resets high, its idle level;
    // trigger enable resets low, so releasing reset with the pin held low gives no false start
    assign trigFall = trigEn_r && trigPrev_r && !extConvTriggerPin_n;
    // Last state of the count; the result is latched on this cycle
    assign convDone = (state_r == ST_CONV) && (cnt_r == 9'h001);
    assign csrWr = regWr && (regAddr == CTRL_STATUS_OFS);
    assign rIdx = regAddr - RESULT_OFS;

    // Conversion sequencer and control/status next values
    always_comb begin
        state_nxt = state_r;
        csr_nxt = csr_r;
        trigEn_nxt = trigEn_r;
        trigPrev_nxt = extConvTriggerPin_n;
        cnt_nxt = cnt_r;
        chan_nxt = chan_r;
        for (int i = 0; i < 4; i++) begin
            result_nxt[i] = result_r[i];
        end
        if (regWr && regAddr == TRIG_CTRL_OFS) begin
            trigEn_nxt = regWdata[TRIG_EN_BIT];
        end
        if (csrWr) begin
            // Done may only be cleared by software, never set
            csr_nxt[6:0] = regWdata[6:0];
            csr_nxt[DONE_BIT] = csr_r[DONE_BIT] & regWdata[DONE_BIT];
        end
        if (trigFall) begin
            csr_nxt[START_BIT] = 1'b1;
        end
        if (regDma && (regWr || regRd)) begin
            csr_nxt[DONE_BIT] = 1'b0;
        end
        // A hardware set of done is applied last, so it wins over a
        // software or DMA clear landing in the same cycle
        case (state_r)
            ST_IDLE: begin
                if (csr_nxt[START_BIT]) begin
                    state_nxt = ST_NEXT;
                    chan_nxt = csrWr ? (regWdata[SCAN_BIT]
                        ? {regWdata[CH_LSB+2], 2'b00}
                        : regWdata[CH_LSB+2:CH_LSB]) : firstCh;
                end
            end
            ST_NEXT: begin
                cnt_nxt = csr_r[CKS_BIT] ? CONV_STATES_FAST
                                         : CONV_STATES_SLOW;
                state_nxt = ST_CONV;
            end
            ST_CONV: begin
                cnt_nxt = cnt_r - 9'h001;
                if (convDone) begin
                    // Result stored with full 10-bit range
                    result_nxt[chan_r[1:0]] = sarCode;
                    if (!csr_r[SCAN_BIT]) begin
                        csr_nxt[DONE_BIT] = 1'b1;
                        csr_nxt[START_BIT] = 1'b0;
                        state_nxt = ST_IDLE;
                    end else if (chan_r == lastCh) begin
                        csr_nxt[DONE_BIT] = 1'b1;
                        chan_nxt = firstCh;
                        state_nxt = ST_NEXT;
                    end else begin
                        chan_nxt = chan_r + 3'h1;
                        state_nxt = ST_NEXT;
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        // Clearing start stops a conversion in flight unless it is in its last state
        if (!csr_nxt[START_BIT] && state_r != ST_IDLE && !convDone) begin
            state_nxt = ST_IDLE;
        end
    end

    // Group and last channel as they will stand after this edge
    assign grpSel = csr_nxt[CH_LSB+2];
    assign grpLast = csr_nxt[CH_LSB+1:CH_LSB];
    assign scanNxt = csr_nxt[SCAN_BIT];

    // Per-pin analog claim; the unused half of port C stays digital
    // for general port use
    for (genvar gp = 0; gp < 8; gp++) begin : g_pin
        localparam logic [2:0] PIN_ID = 3'(gp);
        // Scan claims the whole selected span, single only its channel
        assign pinClaim[gp] = scanNxt
            ? (PIN_ID[2] == grpSel && PIN_ID[1:0] <= grpLast)
            : (PIN_ID == chan_nxt);
    end

    // Request, pin role and read data next values
    always_comb begin
        // Level follows done AND enable
        req_nxt = csr_nxt[DONE_BIT] && csr_nxt[IE_BIT];
        // Pins go back to the digital port once sequencing stops
        pins_nxt = (state_nxt != ST_IDLE) ? pinClaim : 8'h00;
        // Read data is zero outside the cycle after a read strobe,
        // so a stray sample by the master never picks up stale data;
        // a DMA read decodes exactly like a CPU read
        rdata_nxt = 8'h00;
        if (regRd) begin
            if (regAddr == CTRL_STATUS_OFS) begin
                rdata_nxt = csr_r;
            end else if (regAddr == TRIG_CTRL_OFS) begin
                rdata_nxt = {trigEn_r, TRIG_CTRL_RD_ONES[6:0]};
            end else if (rIdx < 4'h8) begin
                // Even index: upper 8 bits, odd: lower 2 bits at top
                rdata_nxt = rIdx[0] ? {result_r[rIdx[2:1]][1:0], 6'h00}
                                    : result_r[rIdx[2:1]][9:2];
            end
        end
    end

    // Registers; reset is synchronous and loads only constants.
    // The result words reset to the minimum code, so reading a result word
    // that no conversion has written returns zero rather than unknown data
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            csr_r <= CTRL_STATUS_RST;
            trigEn_r <= 1'b0;
            trigPrev_r <= 1'b1;
            cnt_r <= 9'h000;
            chan_r <= 3'h0;
            for (int i = 0; i < 4; i++) begin
                result_r[i] <= RES_MIN;
            end
            rdata_r <= 8'h00;
            req_r <= 1'b0;
            pins_r <= 8'h00;
        end else begin
            state_r <= state_nxt;
            csr_r <= csr_nxt;
            trigEn_r <= trigEn_nxt;
            trigPrev_r <= trigPrev_nxt;
            cnt_r <= cnt_nxt;
            chan_r <= chan_nxt;
            for (int i = 0; i < 4; i++) begin
                result_r[i] <= result_nxt[i];
            end
            rdata_r <= rdata_nxt;
            req_r <= req_nxt;
            pins_r <= pins_nxt;
        end
    end

    // Outputs are plain wires from the flops above; no logic is
    // allowed here so each output keeps a single registered source
    // and its timing stays one clock after the cause
    assign regRdata = rdata_r;
    assign convEndRequest = req_r;
    assign analogInputPin = pins_r;
    assign sarChannel = chan_r;

endmodule // conv_ctrl

/* testbench/conv_ctrl_chk.sv */
`timescale 1ns/1ps
module conv_ctrl_chk
    import conv_ctrl_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic sys_rst, // Reset
    input wire logic [3:0] regAddr, // Address
    input wire logic [7:0] regWdata, // Write data
    input wire logic regWr, // Write strobe
    input wire logic regRd, // Read strobe
    input wire logic regDma, // DMA access
    input wire logic [7:0] regRdata, // Read data
    input wire logic convEndRequest, // End request
    input wire logic [7:0] analogInputPin // Analog pins
);
    logic [7:0] csrShadow_r;
    // Shadow of software writes; hardware updates are not mirrored
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            csrShadow_r <= CTRL_STATUS_RST;
        end else if (regWr && !regDma && regAddr == CTRL_STATUS_OFS) begin
            csrShadow_r <= regWdata;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    trig_read_a: assert property (
        $past(regRd) && $past(regAddr) == TRIG_CTRL_OFS |->
        regRdata[6:0] == 7'h7F) else $error("trigger reg readback wrong");
    unmapped_read_a: assert property (
        $past(regRd) && $past(regAddr) > 4'h9 |-> regRdata == 8'h00)
        else $error("unmapped read not zero");
    ie_clear_a: assert property (
        regWr && !regDma && regAddr == CTRL_STATUS_OFS && !regWdata[IE_BIT]
        |-> ##2 !convEndRequest) else $error("request with enable off");
    dma_clear_a: assert property (
        regDma && regRd && convEndRequest |-> ##2 !convEndRequest)
        else $error("dma access left done set");
    group_split_a: assert property (
        analogInputPin[7:4] == 4'h0 || analogInputPin[3:0] == 4'h0)
        else $error("both pin groups analog");
    start_pin_a: assert property (
        regWr && !regDma && regAddr == CTRL_STATUS_OFS &&
        regWdata[START_BIT] && !regWdata[SCAN_BIT] |=>
        analogInputPin == (8'h01 << $past(regWdata[2:0])))
        else $error("start did not claim pin");
    end_req_a: assert property (
        $rose(convEndRequest) |-> csrShadow_r[IE_BIT])
        else $error("request rose while disabled");
    single_end_a: assert property (
        $fell(|analogInputPin) && csrShadow_r[IE_BIT] &&
        csrShadow_r[START_BIT] && !csrShadow_r[SCAN_BIT] |->
        ##[0:2] convEndRequest) else $error("no request at single end");
    cover property ($rose(convEndRequest));
    cover property (regDma && regRd);
    cover property ($fell(|analogInputPin));
endmodule // conv_ctrl_chk
bind conv_ctrl conv_ctrl_chk chk (.mclk, .sys_rst, .regAddr, .regWdata,
    .regWr, .regRd, .regDma, .regRdata, .convEndRequest, .analogInputPin);

/* testbench/dma_model.sv */
`timescale 1ns/1ps
module dma_model
    import conv_ctrl_pkg::*;
(
    input wire logic mclk, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic selConv, // Resource select names the converter
    input wire logic convEndRequest, // Start request
    output logic dmaRd, // One-cycle read strobe
    output logic [3:0] dmaAddr // Read address
);
    logic busy_r;
    // One read per request, rearm only once the request has dropped
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            dmaRd <= 1'b0;
            busy_r <= 1'b0;
        end else if (!busy_r && selConv && convEndRequest) begin
            dmaRd <= 1'b1;
            busy_r <= 1'b1;
        end else begin
            dmaRd <= 1'b0;
            busy_r <= busy_r && convEndRequest;
        end
    end
    assign dmaAddr = RESULT_OFS;
endmodule // dma_model

/* testbench/conv_ctrl_test.sv */
`timescale 1ns/1ps
module conv_ctrl_test;
    import conv_ctrl_pkg::*;
    logic mclk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, cpuRd = 1'b0;
    logic trigPin_n = 1'b1, selConv = 1'b0, dmaRd, convEndRequest;
    logic [3:0] cpuAddr = 4'h0, dmaAddr;
    logic [7:0] regWdata = 8'h00, regRdata, analogInputPin;
    logic [RES_W-1:0] sarCode = 10'h000;
    logic [2:0] ch, sarChannel;
    logic ie;
    logic [3:0] ra;
    int n_mismatch = 0, checks = 0, seed = 44187, k;
    conv_ctrl uut (.mclk, .sys_rst, .regAddr(dmaRd ? dmaAddr : cpuAddr),
        .regWdata, .regWr, .regRd(cpuRd | dmaRd), .regDma(dmaRd), .regRdata,
        .extConvTriggerPin_n(trigPin_n), .sarCode, .convEndRequest,
        .analogInputPin, .sarChannel);
    dma_model dma (.mclk, .sys_rst, .selConv, .convEndRequest, .dmaRd,
        .dmaAddr);
    initial begin
        forever #2 mclk = ~mclk;
    end
    function automatic logic [7:0] resByte(logic [9:0] c, bit lo);
        return lo ? {c[1:0], 6'h00} : c[9:2];
    endfunction
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWr <= 1'b1;
        cpuAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge mclk);
        cpuRd <= 1'b1;
        cpuAddr <= a;
        @(posedge mclk);
        cpuRd <= 1'b0;
        #1 chk(regRdata, exp);
    endtask
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Bounded wait for the request, or for the pins to go digital again
    task automatic waitFor(input bit reqMode);
        for (k = 0; k < 800; k++) begin
            if (reqMode ? convEndRequest === 1'b1 : analogInputPin === 8'h00)
                break;
            @(posedge mclk);
            #1;
        end
        if (k == 800) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(TRIG_CTRL_OFS, TRIG_CTRL_RD_ONES);
        rd(4'hF, 8'h00);
        // Single mode, code extremes first, request enable alternating;
        // the last pass hands the request to the DMA model
        for (int i = 0; i < 5; i++) begin
            ch = (i == 4) ? {1'b1, 2'($random(seed))} : 3'($random(seed));
            ie = i[0] | (i == 4);
            ra = RESULT_OFS + {1'b0, ch[1:0], 1'b0};
            selConv <= (i == 4);
            sarCode <= i == 0 ? RES_MIN
                     : i == 1 ? RES_MAX : 10'($random(seed));
            wr(CTRL_STATUS_OFS, {1'b0, ie, 3'b100, ch});
            @(posedge mclk);
            #1 chk(analogInputPin, 8'h01 << ch);
            chk(sarChannel, ch);
            waitFor(1'b0);
            repeat (8) @(posedge mclk);
            #1 chk(convEndRequest, i == 1 || i == 3);
            rd(CTRL_STATUS_OFS, {i != 4, ie, 3'b000, ch});
            rd(ra, resByte(sarCode, 1'b0));
            rd(ra + 4'h1, resByte(sarCode, 1'b1));
            wr(CTRL_STATUS_OFS, {5'b11000, ch});
            repeat (3) @(posedge mclk);
            #1 chk(convEndRequest, i != 4);
            wr(CTRL_STATUS_OFS, {5'b01000, ch});
            repeat (3) @(posedge mclk);
            #1 chk(convEndRequest, 1'b0);
        end
        selConv <= 1'b0;
        // Scan over channels zero and one keeps running after done
        wr(CTRL_STATUS_OFS, 8'h71);
        waitFor(1'b1);
        rd(CTRL_STATUS_OFS, 8'hF1);
        chk(analogInputPin, 8'h03);
        wr(CTRL_STATUS_OFS, 8'h00);
        waitFor(1'b0);
        // Trigger pulse ignored until trigger enable is set
        for (int t = 0; t < 2; t++) begin
            wr(TRIG_CTRL_OFS, {t[0], 7'h7F});
            wr(CTRL_STATUS_OFS, 8'h42);
            trigPin_n <= 1'b0;
            repeat (2) @(posedge mclk);
            trigPin_n <= 1'b1;
            repeat (8) @(posedge mclk);
            #1 chk(analogInputPin, t ? 8'h04 : 8'h00);
            if (t == 1) begin
                waitFor(1'b1);
            end
        end
        rd(CTRL_STATUS_OFS, 8'hC2);
        report_and_stop();
    end
endmodule // conv_ctrl_test
